/* ppt_pkg.sv */
// package: register map, field layout and reset values of the port block
`default_nettype none
package ppt_pkg;

   // ----------------------------------------------------------------
   // special-function area decode
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 20;
   localparam int          OFFSET_W      = 12;
   localparam logic [11:0] OFF_PA_DATA   = 12'hF00;
   localparam logic [11:0] OFF_PA_DIR    = 12'hF01;
   localparam logic [11:0] OFF_PA_FSEL   = 12'hF02;
   localparam logic [11:0] OFF_PB_DATA   = 12'hF08;
   localparam logic [11:0] OFF_PB_DIR    = 12'hF09;
   localparam logic [11:0] OFF_PB_FSEL   = 12'hF0A;
   localparam logic [11:0] OFF_PC_DATA   = 12'hF10;
   localparam logic [11:0] OFF_PC_DIR    = 12'hF11;
   localparam logic [11:0] OFF_PC_FSEL   = 12'hF12;
   localparam logic [11:0] OFF_CMP_RES   = 12'hF38;
   localparam logic [11:0] OFF_CMP_SEL   = 12'hF3B;
   localparam logic [11:0] OFF_AREA_BASE = 12'hFFF;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_DATA      = 8'h00;
   localparam logic [7:0] RST_DIR       = 8'hFF;
   localparam logic [7:0] RST_FSEL      = 8'h00;
   localparam logic [7:0] RST_CMP_SEL   = 8'h00;
   localparam logic [7:0] RST_AREA_BASE = 8'hFF;
   localparam logic [7:0] RD_UNMAPPED   = 8'h00;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int         PA_CLK_BIT    = 7;
   localparam logic [7:0] PB_FIXED_IN   = 8'h0F;
   localparam logic [7:0] PB_ALT_MASK   = 8'hF0;
   localparam int         PC_HOLD_REQ   = 7;
   localparam int         PC_HOLD_ACK   = 6;
   localparam int         PC_TC_ONE     = 5;
   localparam int         PC_ACK_ONE    = 4;
   localparam int         PC_REQ_ONE    = 3;
   localparam int         PC_REQ_ZERO   = 0;
   localparam logic [7:0] PC_ALT_MASK   = 8'hF9;
   localparam logic [7:0] PC_ALT_OUT    = 8'h70;
   localparam int         CMP_SEL_W     = 4;
   localparam logic [7:0] CMP_SEL_MASK  = 8'h0F;
   localparam logic [4:0] CMP_FULL_FRAC = 5'h10;
   localparam int         CMP_SHIFT     = 4;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] fsel;
   } ppt_port_type;

endpackage
`default_nettype wire

/* ppt_threshold.sv */
// threshold comparator lines with programmable reference fraction
`default_nettype none
module ppt_threshold
   import ppt_pkg::*;
#(
   parameter int LINES   = 8,
   parameter int LEVEL_W = 8
) (
   input  wire logic                              clk_i,
   input  wire logic                              rst_i,
   input  wire logic                              hold_i,
   input  wire logic [CMP_SEL_W-1:0]              sel_i,
   input  wire logic [LEVEL_W-1:0]                ref_level_i,
   input  wire logic [LINES-1:0][LEVEL_W-1:0]     line_level_i,
   output logic      [LINES-1:0]                  result_o
);

   // ----------------------------------------------------------------
   // compare against ref * n / 16 without a divider
   // ----------------------------------------------------------------
   logic [4:0]               frac;
   logic [LEVEL_W+4:0]       ref_scaled;
   logic [LINES-1:0]         raw;
   logic [LINES-1:0]         s1_reg, s2_reg, s3_reg, res_reg;
   logic [LINES-1:0]         s1_next, s2_next, s3_next, res_next;

   always_comb begin
      // code zero means the full fraction
      frac = (sel_i == '0) ? CMP_FULL_FRAC : {1'b0, sel_i};
      ref_scaled = (LEVEL_W+5)'(ref_level_i) * (LEVEL_W+5)'(frac);
      for (int i = 0; i < LINES; i++) begin
         raw[i] = ((LEVEL_W+5)'(line_level_i[i]) << CMP_SHIFT)
                  > ref_scaled;
      end
   end

   // ----------------------------------------------------------------
   // comparator outputs treated as asynchronous: three-stage agree
   // ----------------------------------------------------------------
   always_comb begin
      s1_next  = raw;
      s2_next  = s1_reg;
      s3_next  = s2_reg;
      res_next = res_reg;
      if (!hold_i) begin
         for (int i = 0; i < LINES; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               res_next[i] = s2_reg[i];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         res_reg <= '0;
      end else begin
         s1_reg  <= s1_next;
         s2_reg  <= s2_next;
         s3_reg  <= s3_next;
         res_reg <= res_next;
      end
   end

   assign result_o = res_reg;

endmodule
`default_nettype wire

/* ppt_ports.sv */
// three parallel ports, port B lines 3..0 input only, plus threshold port, sfr mapped
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
module ppt_ports
   import ppt_pkg::*;
#(
   parameter int LEVEL_W = 8
) (
   // clock and reset
   input  wire logic                          CLK_I,
   input  wire logic                          RST_I,
   // cpu special-function access
   input  wire logic [ADDR_W-1:0]             SFR_ADDR_I,
   input  wire logic                          SFR_RD_I,
   input  wire logic                          SFR_WR_I,
   input  wire logic [7:0]                    SFR_WDATA_I,
   output logic      [7:0]                    SFR_RDATA_O,
   output logic                               SFR_HIT_O,
   // standby states
   input  wire logic                          HALT_I,
   input  wire logic                          STOP_I,
   // port pins
   input  wire logic [7:0]                    PA_IN_I,
   output logic      [7:0]                    PA_OUT_O,
   output logic      [7:0]                    PA_OE_O,
   input  wire logic [7:0]                    PB_IN_I,
   output logic      [7:0]                    PB_OUT_O,
   output logic      [7:0]                    PB_OE_O,
   input  wire logic [7:0]                    PC_IN_I,
   output logic      [7:0]                    PC_OUT_O,
   output logic      [7:0]                    PC_OE_O,
   // port B alternate functions: drive on lines 7..4, synchronised pin levels of all 8 lines
   input  wire logic [3:0]                    ALT_B_OUT_I,
   input  wire logic [3:0]                    ALT_B_OE_I,
   output logic      [7:0]                    PB_PIN_O,
   // port C alternate functions
   input  wire logic                          HOLD_ACK_I,
   input  wire logic                          TC_ONE_I,
   input  wire logic                          DMA_ACK_ONE_I,
   output logic                               HOLD_REQ_O,
   output logic                               DMA_REQ_ONE_O,
   output logic                               DMA_REQ_ZERO_O,
   // threshold port
   input  wire logic [LEVEL_W-1:0]            VREF_LEVEL_I,
   input  wire logic [7:0][LEVEL_W-1:0]       THRESH_LEVEL_I
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ppt_port_type      pa_reg, pb_reg, pc_reg;
   ppt_port_type      pa_next, pb_next, pc_next;
   logic [7:0]        cmp_sel_reg, cmp_sel_next;
   logic [7:0]        base_reg, base_next;
   logic [7:0]        rdata_reg, rdata_next;
   logic              hit_reg, hit_next;
   logic              clk_div_reg, clk_div_next;
   logic [23:0]       s1_reg, s2_reg, s3_reg, pin_reg;
   logic [23:0]       s1_next, s2_next, s3_next, pin_next;
   logic [7:0]        pa_out_reg, pa_oe_reg, pb_out_reg, pb_oe_reg;
   logic [7:0]        pc_out_reg, pc_oe_reg;
   logic [7:0]        pa_out_next, pa_oe_next, pb_out_next, pb_oe_next;
   logic [7:0]        pc_out_next, pc_oe_next;
   logic              hreq_reg, rq1_reg, rq0_reg;
   logic              hreq_next, rq1_next, rq0_next;
   logic [7:0]        cmp_res;

   logic              in_area, wr_en, mapped;
   logic [OFFSET_W-1:0] offset;
   logic [7:0]        pa_pin, pb_pin, pc_pin;
   logic [7:0]        pa_rd, pb_rd, pc_rd;

   // ----------------------------------------------------------------
   // threshold comparator
   // ----------------------------------------------------------------
   ppt_threshold #(
      .LINES   (8),
      .LEVEL_W (LEVEL_W)
   ) ppt_threshold_inst (
      .clk_i        (CLK_I),
      .rst_i        (RST_I),
      .hold_i       (STOP_I),
      .sel_i        (cmp_sel_reg[CMP_SEL_W-1:0]),
      .ref_level_i  (VREF_LEVEL_I),
      .line_level_i (THRESH_LEVEL_I),
      .result_o     (cmp_res)
   );

   // ----------------------------------------------------------------
   // address decode and read mux
   // ----------------------------------------------------------------
   always_comb begin
      offset  = SFR_ADDR_I[OFFSET_W-1:0];
      in_area = (SFR_ADDR_I[ADDR_W-1:OFFSET_W] == base_reg);
      unique case (offset)
         OFF_PA_DATA, OFF_PA_DIR, OFF_PA_FSEL,
         OFF_PB_DATA, OFF_PB_DIR, OFF_PB_FSEL,
         OFF_PC_DATA, OFF_PC_DIR, OFF_PC_FSEL,
         OFF_CMP_RES, OFF_CMP_SEL, OFF_AREA_BASE: mapped = 1'b1;
         default:                                mapped = 1'b0;
      endcase
      // cpu inactive in halt and stop, so no access is taken then
      wr_en = SFR_WR_I && in_area && mapped && !HALT_I && !STOP_I;
      pa_pin = pin_reg[7:0];
      pb_pin = pin_reg[15:8];
      pc_pin = pin_reg[23:16];
      pa_rd = (pa_reg.dir & pa_pin) | (~pa_reg.dir & pa_reg.data);
      pb_rd = (pb_reg.dir & pb_pin) | (~pb_reg.dir & pb_reg.data);
      pc_rd = (pc_reg.dir & pc_pin) | (~pc_reg.dir & pc_reg.data);
   end

   always_comb begin
      rdata_next = rdata_reg;
      hit_next   = 1'b0;
      if ((SFR_RD_I || SFR_WR_I) && !HALT_I && !STOP_I) begin
         hit_next = in_area && mapped;
      end
      if (SFR_RD_I && in_area && !HALT_I && !STOP_I) begin
         unique case (offset)
            OFF_PA_DATA:   rdata_next = pa_rd;
            OFF_PA_DIR:    rdata_next = pa_reg.dir;
            OFF_PA_FSEL:   rdata_next = pa_reg.fsel;
            OFF_PB_DATA:   rdata_next = pb_rd;
            OFF_PB_DIR:    rdata_next = pb_reg.dir | PB_FIXED_IN;
            OFF_PB_FSEL:   rdata_next = pb_reg.fsel;
            OFF_PC_DATA:   rdata_next = pc_rd;
            OFF_PC_DIR:    rdata_next = pc_reg.dir;
            OFF_PC_FSEL:   rdata_next = pc_reg.fsel;
            OFF_CMP_RES:   rdata_next = cmp_res;
            OFF_CMP_SEL:   rdata_next = cmp_sel_reg;
            OFF_AREA_BASE: rdata_next = base_reg;
            default:       rdata_next = RD_UNMAPPED;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // register writes; comparator results have no write path
   // ----------------------------------------------------------------
   always_comb begin
      pa_next      = pa_reg;
      pb_next      = pb_reg;
      pc_next      = pc_reg;
      cmp_sel_next = cmp_sel_reg;
      base_next    = base_reg;
      if (wr_en) begin
         unique case (offset)
            OFF_PA_DATA:   pa_next.data = SFR_WDATA_I;
            OFF_PA_DIR:    pa_next.dir  = SFR_WDATA_I;
            OFF_PA_FSEL:   pa_next.fsel = SFR_WDATA_I;
            OFF_PB_DATA:   pb_next.data = SFR_WDATA_I;
            OFF_PB_DIR:    pb_next.dir  = SFR_WDATA_I | PB_FIXED_IN;
            OFF_PB_FSEL:   pb_next.fsel = SFR_WDATA_I;
            OFF_PC_DATA:   pc_next.data = SFR_WDATA_I;
            OFF_PC_DIR:    pc_next.dir  = SFR_WDATA_I;
            OFF_PC_FSEL:   pc_next.fsel = SFR_WDATA_I;
            OFF_CMP_SEL:   cmp_sel_next = SFR_WDATA_I & CMP_SEL_MASK;
            OFF_AREA_BASE: base_next    = SFR_WDATA_I;
            default:       base_next    = base_reg;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin input synchronisers: change accepted when stages 2 and 3 agree
   // ----------------------------------------------------------------
   always_comb begin
      s1_next  = {PC_IN_I, PB_IN_I, PA_IN_I};
      s2_next  = s1_reg;
      s3_next  = s2_reg;
      pin_next = pin_reg;
      for (int i = 0; i < 24; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            pin_next[i] = s2_reg[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------
   always_comb begin
      // clock output is CLK_I/2, the fastest a flop can produce
      clk_div_next = STOP_I ? clk_div_reg : ~clk_div_reg;
      pa_out_next  = pa_out_reg;
      pa_oe_next   = pa_oe_reg;
      pb_out_next  = pb_out_reg;
      pb_oe_next   = pb_oe_reg;
      pc_out_next  = pc_out_reg;
      pc_oe_next   = pc_oe_reg;
      if (!STOP_I) begin
         // latch-driven lines follow the registers, which halt freezes
         for (int i = 0; i < 8; i++) begin
            pa_oe_next[i]  = ~pa_reg.dir[i];
            pa_out_next[i] = pa_reg.data[i];
            pc_oe_next[i]  = ~pc_reg.dir[i];
            pc_out_next[i] = pc_reg.data[i];
            pb_oe_next[i]  = ~pb_reg.dir[i] & PB_ALT_MASK[i];
            pb_out_next[i] = pb_reg.data[i];
            if (pb_reg.fsel[i] && PB_ALT_MASK[i]) begin
               pb_oe_next[i]  = ALT_B_OE_I[i[1:0]];
               pb_out_next[i] = ALT_B_OUT_I[i[1:0]];
            end
            if (pc_reg.fsel[i] && PC_ALT_MASK[i]) begin
               pc_oe_next[i] = PC_ALT_OUT[i];
            end
         end
         if (pa_reg.fsel[PA_CLK_BIT]) begin
            pa_oe_next[PA_CLK_BIT]  = 1'b1;
            pa_out_next[PA_CLK_BIT] = clk_div_reg;
         end
         if (pc_reg.fsel[PC_HOLD_ACK]) begin
            pc_out_next[PC_HOLD_ACK] = HOLD_ACK_I;
         end
         if (pc_reg.fsel[PC_TC_ONE]) begin
            pc_out_next[PC_TC_ONE] = TC_ONE_I;
         end
         if (pc_reg.fsel[PC_ACK_ONE]) begin
            pc_out_next[PC_ACK_ONE] = DMA_ACK_ONE_I;
         end
      end
      // alternate inputs read as idle low unless their line is given over
      hreq_next = pc_reg.fsel[PC_HOLD_REQ] & pc_pin[PC_HOLD_REQ];
      rq1_next  = pc_reg.fsel[PC_REQ_ONE]  & pc_pin[PC_REQ_ONE];
      rq0_next  = pc_reg.fsel[PC_REQ_ZERO] & pc_pin[PC_REQ_ZERO];
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         pa_reg      <= '{data: RST_DATA, dir: RST_DIR, fsel: RST_FSEL};
         pb_reg      <= '{data: RST_DATA, dir: RST_DIR, fsel: RST_FSEL};
         pc_reg      <= '{data: RST_DATA, dir: RST_DIR, fsel: RST_FSEL};
         cmp_sel_reg <= RST_CMP_SEL;
         base_reg    <= RST_AREA_BASE;
         rdata_reg   <= RD_UNMAPPED;
         hit_reg     <= 1'b0;
         clk_div_reg <= 1'b0;
         s1_reg      <= '0;
         s2_reg      <= '0;
         s3_reg      <= '0;
         pin_reg     <= '0;
         pa_out_reg  <= '0;
         pa_oe_reg   <= '0;
         pb_out_reg  <= '0;
         pb_oe_reg   <= '0;
         pc_out_reg  <= '0;
         pc_oe_reg   <= '0;
         hreq_reg    <= 1'b0;
         rq1_reg     <= 1'b0;
         rq0_reg     <= 1'b0;
      end else begin
         pa_reg      <= pa_next;
         pb_reg      <= pb_next;
         pc_reg      <= pc_next;
         cmp_sel_reg <= cmp_sel_next;
         base_reg    <= base_next;
         rdata_reg   <= rdata_next;
         hit_reg     <= hit_next;
         clk_div_reg <= clk_div_next;
         s1_reg      <= s1_next;
         s2_reg      <= s2_next;
         s3_reg      <= s3_next;
         pin_reg     <= pin_next;
         pa_out_reg  <= pa_out_next;
         pa_oe_reg   <= pa_oe_next;
         pb_out_reg  <= pb_out_next;
         pb_oe_reg   <= pb_oe_next;
         pc_out_reg  <= pc_out_next;
         pc_oe_reg   <= pc_oe_next;
         hreq_reg    <= hreq_next;
         rq1_reg     <= rq1_next;
         rq0_reg     <= rq0_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign SFR_RDATA_O    = rdata_reg;
   assign SFR_HIT_O      = hit_reg;
   assign PA_OUT_O       = pa_out_reg;
   assign PA_OE_O        = pa_oe_reg;
   assign PB_OUT_O       = pb_out_reg;
   assign PB_OE_O        = pb_oe_reg;
   assign PC_OUT_O       = pc_out_reg;
   assign PC_OE_O        = pc_oe_reg;
   assign PB_PIN_O       = pin_reg[15:8];
   assign HOLD_REQ_O     = hreq_reg;
   assign DMA_REQ_ONE_O  = rq1_reg;
   assign DMA_REQ_ZERO_O = rq0_reg;

endmodule
`default_nettype wire

/* ppt_ports_checker.sv */
// checker: bus, pin and standby relations at the port block boundary
`default_nettype none
module ppt_ports_checker
   import ppt_pkg::*;
(
   // clock, reset, bus and standby
   input wire logic              CLK_I,
   input wire logic              RST_I,
   input wire logic [ADDR_W-1:0] SFR_ADDR_I,
   input wire logic              SFR_RD_I,
   input wire logic              SFR_WR_I,
   input wire logic [7:0]        SFR_WDATA_I,
   input wire logic [7:0]        SFR_RDATA_O,
   input wire logic              SFR_HIT_O,
   input wire logic              HALT_I,
   input wire logic              STOP_I,
   // pins
   input wire logic [7:0]        PA_OUT_O,
   input wire logic [7:0]        PA_OE_O,
   input wire logic [7:0]        PB_OUT_O,
   input wire logic [7:0]        PB_OE_O,
   input wire logic [7:0]        PC_OUT_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   logic [11:0] off;
   logic        in_area;
   logic        mapped;
   logic        base_hit;
   logic [7:0]  base_reg;
   logic [7:0]  base_next;
   assign off = SFR_ADDR_I[11:0];
   // mirror of the area base, so a relocated area is still judged right
   always_comb begin
      base_next = base_reg;
      if (SFR_WR_I && in_area && off == OFF_AREA_BASE) begin
         base_next = SFR_WDATA_I;
      end
   end
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         base_reg <= RST_AREA_BASE;
      end else begin
         base_reg <= base_next;
      end
   end
   assign base_hit = SFR_ADDR_I[19:12] == base_reg;
   assign in_area = base_hit && !HALT_I && !STOP_I;
   assign mapped = off inside {OFF_PA_DATA, OFF_PA_DIR, OFF_PA_FSEL,
      OFF_PB_DATA, OFF_PB_DIR, OFF_PB_FSEL, OFF_PC_DATA, OFF_PC_DIR,
      OFF_PC_FSEL, OFF_CMP_RES, OFF_CMP_SEL, OFF_AREA_BASE};
   sequence taken_s;
      (SFR_RD_I || SFR_WR_I) && in_area;
   endsequence
   sequence wr_s(logic [11:0] o);
      SFR_WR_I && in_area && off == o;
   endsequence
   AST_MAPPED_HIT: assert property (taken_s ##0 mapped |=> SFR_HIT_O)
      else $error("mapped access gave no hit");
   AST_UNMAPPED_HIT: assert property (taken_s ##0 !mapped
      |=> !SFR_HIT_O) else $error("unmapped access gave a hit");
   AST_UNMAPPED_DATA: assert property (SFR_RD_I && in_area && !mapped
      |=> SFR_RDATA_O == RD_UNMAPPED) else $error("unmapped read data");
   AST_OUTSIDE: assert property ((SFR_RD_I || SFR_WR_I)
      && !base_hit |=> !SFR_HIT_O && $stable(SFR_RDATA_O))
      else $error("access outside area answered");
   AST_HIT_CAUSE: assert property (SFR_HIT_O
      |-> $past(SFR_RD_I) || $past(SFR_WR_I))
      else $error("hit without access");
   AST_HALT_QUIET: assert property (HALT_I |=> !SFR_HIT_O)
      else $error("access taken in halt");
   AST_STOP_FREEZE: assert property (STOP_I [*2] |=> $stable(PA_OUT_O)
      && $stable(PA_OE_O) && $stable(PB_OUT_O) && $stable(PC_OUT_O))
      else $error("pins moved in stop");
   AST_PB_LOW_IN: assert property ((PB_OE_O & 8'h0F) == 8'h00)
      else $error("port b low lines driven");
   AST_PA_DIR_OE: assert property (wr_s(OFF_PA_DIR) ##1 !STOP_I |=>
      ((PA_OE_O ^ ~$past(SFR_WDATA_I, 2)) & 8'h7F) == 8'h00)
      else $error("port a enable differs from direction");
   AST_PA_DATA_OUT: assert property (wr_s(OFF_PA_DATA) ##1 !STOP_I |=>
      (PA_OE_O & (PA_OUT_O ^ $past(SFR_WDATA_I, 2)) & 8'h7F) == 8'h00)
      else $error("port a drive differs from latch");
endmodule
bind ppt_ports ppt_ports_checker ppt_ports_checker_inst (.CLK_I, .RST_I,
   .SFR_ADDR_I, .SFR_RD_I, .SFR_WR_I, .SFR_WDATA_I, .SFR_RDATA_O,
   .SFR_HIT_O, .HALT_I, .STOP_I, .PA_OUT_O, .PA_OE_O, .PB_OUT_O,
   .PB_OE_O, .PC_OUT_O);
`default_nettype wire

/* ppt_pins_model.sv */
// pin model: resolves each port line between block and far-side driver
`default_nettype none
module ppt_pins_model (
   // clock
   input  wire logic             clk_i,
   // block side and far side
   input  wire logic [2:0][7:0]  out_i,
   input  wire logic [2:0][7:0]  oe_i,
   input  wire logic [2:0][7:0]  ext_val_i,
   input  wire logic [2:0][7:0]  ext_en_i,
   output logic      [2:0][7:0]  pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tog_reg;
   initial tog_reg = 8'h55;
   always @(posedge clk_i) tog_reg <= ~tog_reg;
   // undriven lines wander so a stale level never passes for a match
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         pin_o[p] = (oe_i[p] & out_i[p])
            | (~oe_i[p] & ext_en_i[p] & ext_val_i[p])
            | (~oe_i[p] & ~ext_en_i[p] & tog_reg);
      end
   end
endmodule
`default_nettype wire

/* ppt_ports_bench.sv */
// testbench: register accesses, pin behaviour and standby checks
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
   n_fail++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module ppt_ports_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ppt_pkg::*;
   logic clk, rst, rd, wr, halt, stop, hit, hack, tc1, ack1, hreq, rq1, rq0;
   logic [19:0]     addr;
   logic [7:0]      wd, rdata, pbpin, vref, e8, t8;
   logic [2:0][7:0] out, oe, ev, een, pin;
   logic [3:0]      alt_o, alt_e;
   logic [7:0][7:0] lvl;
   int              n_fail, checked;
   ppt_ports ppt_ports_inst (.CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr),
      .SFR_RD_I(rd), .SFR_WR_I(wr), .SFR_WDATA_I(wd), .SFR_RDATA_O(rdata),
      .SFR_HIT_O(hit), .HALT_I(halt), .STOP_I(stop), .PA_IN_I(pin[0]),
      .PA_OUT_O(out[0]), .PA_OE_O(oe[0]), .PB_IN_I(pin[1]),
      .PB_OUT_O(out[1]), .PB_OE_O(oe[1]), .PC_IN_I(pin[2]),
      .PC_OUT_O(out[2]), .PC_OE_O(oe[2]), .ALT_B_OUT_I(alt_o),
      .ALT_B_OE_I(alt_e), .PB_PIN_O(pbpin), .HOLD_ACK_I(hack),
      .TC_ONE_I(tc1), .DMA_ACK_ONE_I(ack1), .HOLD_REQ_O(hreq),
      .DMA_REQ_ONE_O(rq1), .DMA_REQ_ZERO_O(rq0), .VREF_LEVEL_I(vref),
      .THRESH_LEVEL_I(lvl));
   ppt_pins_model ppt_pins_model_inst (.clk_i(clk), .out_i(out),
      .oe_i(oe), .ext_val_i(ev), .ext_en_i(een), .pin_o(pin));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic acc(input logic [19:0] a, input logic w,
                      input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wr = w;
      rd = !w;
      wd = d;
      @(negedge clk);
      rd = 1'b0;
      wr = 1'b0;
   endtask
   task automatic wrr(input logic [11:0] o, input logic [7:0] d);
      acc({8'hFF, o}, 1'b1, d);
   endtask
   task automatic rdc(input logic [11:0] o, input logic [7:0] e,
                      input logic h);
      acc({8'hFF, o}, 1'b0, 8'h00);
      `CHK("read data", e, rdata)
      `CHK("hit", h, hit)
   endtask
   task automatic summarize;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      summarize();
   end
   initial begin
      {rst, rd, wr, halt, stop, hack, tc1, ack1} = 8'h80;
      {addr, wd, alt_o, alt_e, vref} = '0;
      ev = {3{8'h3C}};
      een = {3{8'hFF}};
      for (int i = 0; i < 8; i++) lvl[i] = 8'(i * 36);
      cyc(2);
      rst = 1'b0;
      rdc(OFF_PA_DIR, RST_DIR, 1'b1);
      rdc(OFF_PC_FSEL, RST_FSEL, 1'b1);
      rdc(OFF_CMP_SEL, RST_CMP_SEL, 1'b1);
      `CHK("enables after reset", 24'h0, oe)
      for (int p = 0; p < 3; p++) begin
         wrr(OFF_PA_DIR + 12'(p * 8), 8'h0F);
         wrr(OFF_PA_DATA + 12'(p * 8), 8'hA5);
         cyc(6);
         `CHK("line enable", 8'hF0, oe[p])
         `CHK("line drive", 8'hA0, out[p] & 8'hF0)
         rdc(OFF_PA_DATA + 12'(p * 8), 8'hAC, 1'b1);
      end
      wrr(OFF_PB_DIR, 8'h00);
      rdc(OFF_PB_DIR, 8'h0F, 1'b1);
      `CHK("port b pins", 8'hAC, pbpin)
      alt_o = 4'hF;
      alt_e = 4'hA;
      wrr(OFF_PB_FSEL, 8'hF0);
      cyc(4);
      `CHK("port b alt enable", 8'hA0, oe[1])
      `CHK("port b alt drive", 8'hA0, out[1] & 8'hA0)
      halt = 1'b1;
      wrr(OFF_PA_DATA, 8'h00);
      `CHK("hit in halt", 1'b0, hit)
      halt = 1'b0;
      rdc(OFF_PA_DATA, 8'hAC, 1'b1);
      wrr(OFF_PA_FSEL, 8'h80);
      cyc(2);
      t8 = out[0];
      `CHK("clock line enable", 1'b1, oe[0][7])
      cyc(1);
      `CHK("clock line toggles", ~t8[7], out[0][7])
      stop = 1'b1;
      cyc(1);
      t8 = out[0];
      e8 = out[1];
      alt_o = 4'h0;
      cyc(3);
      `CHK("port a frozen", t8, out[0])
      `CHK("port b frozen", e8, out[1])
      stop = 1'b0;
      {hack, tc1, ack1} = 3'b101;
      ev[2] = 8'h89;
      wrr(OFF_PC_FSEL, 8'hF9);
      cyc(6);
      `CHK("port c alt enable", 8'h70, oe[2] & 8'hF9)
      `CHK("port c alt drive", 8'h50, out[2] & 8'h70)
      `CHK("port c requests", 3'b111, {hreq, rq1, rq0})
      ev[2] = 8'h00;
      cyc(6);
      `CHK("port c requests low", 3'b000, {hreq, rq1, rq0})
      vref = 8'h80;
      for (int k = 0; k < 16; k++) begin
         wrr(OFF_CMP_SEL, 8'(k));
         cyc(6);
         for (int i = 0; i < 8; i++)
            e8[i] = int'(lvl[i]) * 16 > 128 * (k == 0 ? 16 : k);
         rdc(OFF_CMP_RES, e8, 1'b1);
         rdc(OFF_CMP_SEL, 8'(k), 1'b1);
      end
      wrr(OFF_CMP_RES, 8'hFF);
      rdc(OFF_CMP_RES, e8, 1'b1);
      wrr(12'hF03, 8'h5A);
      rdc(12'hF03, RD_UNMAPPED, 1'b0);
      t8 = rdata;
      acc(20'h12F00, 1'b0, 8'h00);
      `CHK("outside read data", t8, rdata)
      `CHK("outside hit", 1'b0, hit)
      wrr(OFF_AREA_BASE, 8'h12);
      acc(20'h12F01, 1'b0, 8'h00);
      `CHK("moved area read", 8'h0F, rdata)
      `CHK("moved area hit", 1'b1, hit)
      acc(20'hFFF01, 1'b0, 8'h00);
      `CHK("old area read", 8'h0F, rdata)
      `CHK("old area hit", 1'b0, hit)
      acc(20'h12FFF, 1'b1, 8'hFF);
      rdc(OFF_AREA_BASE, RST_AREA_BASE, 1'b1);
      summarize();
   end
endmodule
`undef CHK
`default_nettype wire
